// >>> src/lpw_regs.svh
`ifndef LPW_REGS_SVH
`define LPW_REGS_SVH
// recovery counter loads: the count runs down to zero, so load is cycles minus one
`define LPW_REC_LOAD_FULL  12'hFFF
`define LPW_REC_LOAD_SHORT 12'h01F
`define LPW_REC_ZERO       12'h000
`define LPW_REC_ONE        12'h001
// recovery lengths in oscillator cycles
`define LPW_REC_FULL_CYC   13'h1000
`define LPW_REC_SHORT_CYC  13'h0020
`define LPW_LEN_ONE        13'h0001
// vector pair base addresses
`define LPW_VEC_RESET      16'hFFFE
`define LPW_VEC_BREAK      16'hFFFC
`define LPW_VEC_EXT_INT    16'hFFFA
`define LPW_VEC_CLKGEN     16'hFFF8
`define LPW_VEC_T1_CH0     16'hFFF6
`define LPW_VEC_T1_CH1     16'hFFF4
`define LPW_VEC_T1_OVF     16'hFFF2
`define LPW_VEC_T2_CH0     16'hFFF0
`define LPW_VEC_T2_CH1     16'hFFEE
`define LPW_VEC_T2_OVF     16'hFFEC
`define LPW_VEC_SSI_RX     16'hFFEA
`define LPW_VEC_SSI_TX     16'hFFE8
`define LPW_VEC_ASI_ERR    16'hFFE6
`define LPW_VEC_ASI_RX     16'hFFE4
`define LPW_VEC_ASI_TX     16'hFFE2
`define LPW_VEC_KEYPAD     16'hFFE0
`define LPW_VEC_ADC        16'hFFDE
`define LPW_VEC_TIMEBASE   16'hFFDC
`define LPW_VEC_CAN_WAKE   16'hFFDA
`define LPW_VEC_CAN_ERR    16'hFFD8
`define LPW_VEC_CAN_RX     16'hFFD6
`define LPW_VEC_CAN_TX     16'hFFD4
`define LPW_VEC_T2_CH2     16'hFFD2
`define LPW_VEC_T2_CH3     16'hFFD0
`define LPW_VEC_T2_CH4     16'hFFCE
`define LPW_VEC_T2_CH5     16'hFFCC
`define LPW_VEC_NONE       16'h0000
`endif

// >>> src/lpw_pkg.sv
package lpw_pkg;
  typedef logic [15:0] vec_addr_t;
  typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_STOP, MODE_RECOVER} lp_mode_t;
  typedef struct packed {
    logic        busy;
    logic        done;
    logic        short_sel;
    logic [11:0] cnt;
  } rec_state_t;
  typedef struct packed {
    lp_mode_t    mode;
    logic [7:0]  kp_prev;
    logic        irq_prev;
    logic        exit_by_reset;
    vec_addr_t   pend_vec;
    logic        rec_start;
    logic        rec_short;
    logic        cpu_clock_en;
    logic        bus_clock_en;
    logic        in_wait;
    logic        in_stop;
    logic        watchdog_clock_in;
    logic        sic_clear;
    logic        ssi_freeze;
    logic        ssi_abort;
    logic        periph_halt;
    logic        timebase_run;
    logic        access_block;
    logic        reset_req;
    logic        vector_load;
    vec_addr_t   vector_addr;
    logic        recovering;
  } ctl_state_t;
  localparam ctl_state_t CTL_RESET = '{mode: MODE_RUN, irq_prev: 1'b1, cpu_clock_en: 1'b1,
                                       bus_clock_en: 1'b1, watchdog_clock_in: 1'b1,
                                       timebase_run: 1'b1, default: '0};
endpackage

// >>> src/recovery_if.sv
`timescale 1ns/10ps
`default_nettype none
interface recovery_if;
  logic start;
  logic short_sel;
  logic busy;
  logic done;
  modport ctrl    (output start, output short_sel, input busy, input done);
  modport counter (input start, input short_sel, output busy, output done);
endinterface
`default_nettype wire

// >>> src/stop_recovery_counter.sv
`timescale 1ns/10ps
`default_nettype none
`include "lpw_regs.svh"
module stop_recovery_counter (
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  recovery_if.counter rec
);
  import lpw_pkg::*;

  rec_state_t  r;
  rec_state_t  next_r;
  logic [12:0] busy_len;

  // 12-bit down counter holds clocks off for the full or short delay
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (rec.start) begin
      next_r.busy      = 1'b1;
      next_r.short_sel = rec.short_sel;
      next_r.cnt       = rec.short_sel ? `LPW_REC_LOAD_SHORT : `LPW_REC_LOAD_FULL; // see RULE22
    end else if (r.busy) begin
      if (r.cnt == `LPW_REC_ZERO) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end else begin
        next_r.cnt = r.cnt - `LPW_REC_ONE;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rec.busy = r.busy;
  assign rec.done = r.done;

  // helper: length of the busy window, read only by the check below
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy_len <= '0;
    end else if (r.busy) begin
      busy_len <= busy_len + `LPW_LEN_ONE;
    end else begin
      busy_len <= '0;
    end
  end

  chk_recovery_length: assert property (@(posedge clk_sys) disable iff (!resetn) // see RULE22
    $fell(r.busy) |-> busy_len == (r.short_sel ? `LPW_REC_SHORT_CYC : `LPW_REC_FULL_CYC))
    else $error("recovery delay length wrong");
endmodule
`default_nettype wire

// >>> src/low_power_wakeup_control.sv
// Summary of operation
// (RULE1) watchdog keeps counting in wait; its enabled expiry resets the device.
// (RULE2) stop gates the watchdog clock and clears the integration counter.
// (RULE3) stop instruction is ignored unless the stop-enable bit is set.
// (RULE4) external interrupt pin wakes from wait and stop when unmasked.
// (RULE5) keypad requests wake from wait and stop when unmasked.
// (RULE6) enabled voltage monitor reset ends wait, and stop when enabled in stop.
// (RULE7) serial and timer interrupts wake the processor from wait.
// (RULE8) sync serial freezes in stop; reset exit aborts and resets it.
// (RULE9) timers halt in stop with state kept, resume after interrupt exit.
// (RULE10) timebase runs in stop only with oscillator-in-stop set.
// (RULE11) timebase and network registers are blocked to the processor in wait.
// (RULE12) network and async serial go inactive in stop, registers kept.
// (RULE13) pin, watchdog and monitor resets fetch the top reset vector pair.
// (RULE14) external interrupt and emulation break have their own vector pairs.
// (RULE15) clock generator and keypad interrupts have their own vector pairs.
// (RULE16) first timer vectors: overflow, channel 1, channel 0 ascending.
// (RULE17) second timer: overflow/ch1/ch0 high range, ch5..ch2 lower range.
// (RULE18) sync serial tx/rx and async tx/rx/error vectors, ascending.
// (RULE19) converter vector sits just above the timebase vector.
// (RULE20) network tx/rx/error/wake vectors; bus activity wakes from stop.
// (RULE21) keypad edge per polarity bit and timebase rollover wake from stop.
// (RULE22) stop exit waits 4096 oscillator cycles, or 32 with short recovery.
`timescale 1ns/10ps
`default_nettype none
`include "lpw_regs.svh"
module low_power_wakeup_control (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       wait_req,
  input  wire logic       stop_req,
  input  wire logic       stop_enable,
  input  wire logic       short_recovery_bit,
  input  wire logic       osc_in_stop_enable,
  input  wire logic       watchdog_enable,
  input  wire logic       watchdog_expired,
  input  wire logic       reset_pin_n,
  input  wire logic       ext_int_n,
  input  wire logic       ext_int_mask_bit,
  input  wire logic [7:0] keypad_pins,
  input  wire logic [7:0] keypad_enable,
  input  wire logic [7:0] keypad_polarity_bits,
  input  wire logic       keypad_mask_bit,
  input  wire logic       svm_enable,
  input  wire logic       svm_reset_enable,
  input  wire logic       svm_stop_enable,
  input  wire logic       svm_trip,
  input  wire logic       break_req,
  input  wire logic       emulation_mode,
  input  wire logic       clkgen_irq,
  input  wire logic [2:0] first_timer_irq,
  input  wire logic [6:0] second_timer_irq,
  input  wire logic [1:0] sync_serial_irq,
  input  wire logic [2:0] async_serial_irq,
  input  wire logic       adc_irq,
  input  wire logic       timebase_irq,
  input  wire logic [3:0] can_irq,
  input  wire logic       can_bus_activity,
  output logic            cpu_clock_en,
  output logic            bus_clock_en,
  output logic            in_wait,
  output logic            in_stop,
  output logic            recovering,
  output logic            watchdog_clock_in,
  output logic            sic_clear,
  output logic            sync_serial_freeze,
  output logic            sync_serial_abort,
  output logic            periph_halt,
  output logic            timebase_run,
  output logic            access_block,
  output logic            reset_req,
  output logic            vector_load,
  output lpw_pkg::vec_addr_t vector_addr
);
  import lpw_pkg::*;

  ctl_state_t r;
  ctl_state_t next_r;
  recovery_if rec ();

  logic       ext_fall;
  logic       irq_wake;
  logic [7:0] kp_edge;
  logic       kp_wake;
  logic       brk;
  logic       svm_rst;
  logic       run_rst;
  logic       stop_rst;
  logic       stop_wake;
  logic       wait_wake;
  logic       stop_mode;
  logic       halted;
  vec_addr_t  wait_vec;
  vec_addr_t  stop_vec;

  // highest address wins, so the chain runs from the top vector pair down
  function automatic vec_addr_t pick_vector(
    input logic       b_brk,
    input logic       b_irq,
    input logic       b_cgm,
    input logic [2:0] b_t1,
    input logic [6:0] b_t2,
    input logic [1:0] b_ssi,
    input logic [2:0] b_asi,
    input logic       b_kp,
    input logic       b_adc,
    input logic       b_tb,
    input logic [3:0] b_can
  );
    vec_addr_t v;
    v = `LPW_VEC_NONE;
    if (b_brk) begin
      v = `LPW_VEC_BREAK;      // see RULE14
    end else if (b_irq) begin
      v = `LPW_VEC_EXT_INT;    // see RULE14
    end else if (b_cgm) begin
      v = `LPW_VEC_CLKGEN;     // see RULE15
    end else if (b_t1[2]) begin
      v = `LPW_VEC_T1_CH0;     // see RULE16
    end else if (b_t1[1]) begin
      v = `LPW_VEC_T1_CH1;
    end else if (b_t1[0]) begin
      v = `LPW_VEC_T1_OVF;
    end else if (b_t2[2]) begin
      v = `LPW_VEC_T2_CH0;     // see RULE17
    end else if (b_t2[1]) begin
      v = `LPW_VEC_T2_CH1;
    end else if (b_t2[0]) begin
      v = `LPW_VEC_T2_OVF;
    end else if (b_ssi[1]) begin
      v = `LPW_VEC_SSI_RX;     // see RULE18
    end else if (b_ssi[0]) begin
      v = `LPW_VEC_SSI_TX;
    end else if (b_asi[2]) begin
      v = `LPW_VEC_ASI_ERR;
    end else if (b_asi[1]) begin
      v = `LPW_VEC_ASI_RX;
    end else if (b_asi[0]) begin
      v = `LPW_VEC_ASI_TX;
    end else if (b_kp) begin
      v = `LPW_VEC_KEYPAD;     // see RULE15
    end else if (b_adc) begin
      v = `LPW_VEC_ADC;        // see RULE19
    end else if (b_tb) begin
      v = `LPW_VEC_TIMEBASE;
    end else if (b_can[3]) begin
      v = `LPW_VEC_CAN_WAKE;   // see RULE20
    end else if (b_can[2]) begin
      v = `LPW_VEC_CAN_ERR;
    end else if (b_can[1]) begin
      v = `LPW_VEC_CAN_RX;
    end else if (b_can[0]) begin
      v = `LPW_VEC_CAN_TX;
    end else if (b_t2[3]) begin
      v = `LPW_VEC_T2_CH2;     // see RULE17
    end else if (b_t2[4]) begin
      v = `LPW_VEC_T2_CH3;
    end else if (b_t2[5]) begin
      v = `LPW_VEC_T2_CH4;
    end else if (b_t2[6]) begin
      v = `LPW_VEC_T2_CH5;
    end
    return v;
  endfunction

  // edge and level detectors stay live in every mode
  assign ext_fall = r.irq_prev & ~ext_int_n;
  assign irq_wake = ext_fall & ~ext_int_mask_bit;                        // see RULE4
  assign kp_edge  = keypad_enable & ((keypad_polarity_bits & ~r.kp_prev & keypad_pins) |
                                     (~keypad_polarity_bits & r.kp_prev & ~keypad_pins));
  assign kp_wake  = (|kp_edge) & ~keypad_mask_bit;                       // see RULE5
  assign brk      = break_req & emulation_mode;
  assign svm_rst  = svm_enable & svm_reset_enable & svm_trip;            // see RULE6

  // watchdog only counts outside stop and recovery, so its expiry matters in run and wait
  assign run_rst  = ~reset_pin_n | (watchdog_enable & watchdog_expired) | svm_rst; // see RULE1
  assign stop_rst = ~reset_pin_n | (svm_rst & svm_stop_enable);          // see RULE6

  // in stop only pin, keypad, break, timebase rollover and bus activity run
  assign stop_wake = brk | irq_wake | kp_wake | can_bus_activity |
                     (timebase_irq & osc_in_stop_enable);                 // see RULE21
  assign wait_wake = brk | irq_wake | kp_wake | clkgen_irq | adc_irq | timebase_irq |
                     (|first_timer_irq) | (|second_timer_irq) | (|sync_serial_irq) |
                     (|async_serial_irq) | (|can_irq);                   // see RULE7

  assign wait_vec = pick_vector(brk, irq_wake, clkgen_irq, first_timer_irq, second_timer_irq,
                                sync_serial_irq, async_serial_irq, kp_wake, adc_irq,
                                timebase_irq, can_irq);
  assign stop_vec = pick_vector(brk, irq_wake, 1'b0, 3'h0, 7'h00, 2'h0, 3'h0, kp_wake, 1'b0,
                                timebase_irq & osc_in_stop_enable,
                                {can_bus_activity, 3'h0});               // see RULE20

  assign stop_mode = (r.mode == MODE_STOP);
  assign halted    = stop_mode | (r.mode == MODE_RECOVER);

  // mode sequencer; outputs follow the registered mode one cycle later
  always_comb begin
    next_r             = r;
    next_r.kp_prev     = keypad_pins;
    next_r.irq_prev    = ext_int_n;
    next_r.rec_start   = 1'b0;
    next_r.sic_clear   = 1'b0;
    next_r.ssi_abort   = 1'b0;
    next_r.reset_req   = 1'b0;
    next_r.vector_load = 1'b0;
    case (r.mode)
      MODE_RUN: begin
        if (run_rst) begin
          next_r.reset_req   = 1'b1;
          next_r.vector_load = 1'b1;
          next_r.vector_addr = `LPW_VEC_RESET;                           // see RULE13
        end else if (stop_req && stop_enable) begin                       // see RULE3
          next_r.mode      = MODE_STOP;
          next_r.sic_clear = 1'b1;                                        // see RULE2
        end else if (wait_req) begin
          next_r.mode = MODE_WAIT;
        end
      end
      MODE_WAIT: begin
        if (run_rst) begin
          next_r.mode        = MODE_RUN;
          next_r.reset_req   = 1'b1;                                      // see RULE1
          next_r.vector_load = 1'b1;
          next_r.vector_addr = `LPW_VEC_RESET;                           // see RULE13
        end else if (wait_wake) begin
          next_r.mode        = MODE_RUN;
          next_r.vector_load = 1'b1;
          next_r.vector_addr = wait_vec;
        end
      end
      MODE_STOP: begin
        // a reset exit still waits out the recovery count before the vector
        if (stop_rst) begin
          next_r.mode          = MODE_RECOVER;
          next_r.exit_by_reset = 1'b1;
          next_r.pend_vec      = `LPW_VEC_RESET;                         // see RULE13
          next_r.rec_start     = 1'b1;
          next_r.rec_short     = short_recovery_bit;
        end else if (stop_wake) begin
          next_r.mode          = MODE_RECOVER;
          next_r.exit_by_reset = 1'b0;
          next_r.pend_vec      = stop_vec;
          next_r.rec_start     = 1'b1;
          next_r.rec_short     = short_recovery_bit;                      // see RULE22
        end
      end
      MODE_RECOVER: begin
        if (rec.done) begin
          next_r.mode        = MODE_RUN;
          next_r.vector_load = 1'b1;
          next_r.vector_addr = r.pend_vec;
          next_r.reset_req   = r.exit_by_reset;
          next_r.ssi_abort   = r.exit_by_reset;                           // see RULE8
        end
      end
      default: begin
        next_r.mode = MODE_RUN;
      end
    endcase

    // clock gating and peripheral controls from the current mode
    next_r.cpu_clock_en      = (r.mode == MODE_RUN);
    next_r.bus_clock_en      = (r.mode == MODE_RUN) || (r.mode == MODE_WAIT) ||
                               (stop_mode && osc_in_stop_enable);
    next_r.in_wait           = (r.mode == MODE_WAIT);
    next_r.in_stop           = stop_mode;
    next_r.recovering        = (r.mode == MODE_RECOVER);
    next_r.watchdog_clock_in = !halted;                                   // see RULE2
    next_r.ssi_freeze        = halted;                                    // see RULE8
    next_r.periph_halt       = halted;                                    // see RULE9
    next_r.timebase_run      = !(halted && !osc_in_stop_enable);          // see RULE10
    next_r.access_block      = (r.mode != MODE_RUN);                      // see RULE11
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r <= CTL_RESET;
    end else begin
      r <= next_r;
    end
  end

  // recovery delay handshake
  assign rec.start     = r.rec_start;
  assign rec.short_sel = r.rec_short;

  stop_recovery_counter u_recovery (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .rec     (rec.counter)
  );

  // network and async serial share the timer halt: no clock, registers kept
  assign cpu_clock_en       = r.cpu_clock_en;
  assign bus_clock_en       = r.bus_clock_en;
  assign in_wait            = r.in_wait;
  assign in_stop            = r.in_stop;
  assign recovering         = r.recovering;
  assign watchdog_clock_in  = r.watchdog_clock_in;
  assign sic_clear          = r.sic_clear;
  assign sync_serial_freeze = r.ssi_freeze;
  assign sync_serial_abort  = r.ssi_abort;
  assign periph_halt        = r.periph_halt;                              // see RULE12
  assign timebase_run       = r.timebase_run;
  assign access_block       = r.access_block;
  assign reset_req          = r.reset_req;
  assign vector_load        = r.vector_load;
  assign vector_addr        = r.vector_addr;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_stop_entry;
    (r.mode == MODE_RUN) && !run_rst && stop_req && stop_enable;
  endsequence
  sequence s_stop_gated;
    sic_clear ##1 (in_stop && !watchdog_clock_in);
  endsequence

  chk_stop_gating: assert property (s_stop_entry |=> s_stop_gated) // see RULE2
    else $error("stop entry did not gate the watchdog");
  chk_stop_disabled: assert property ( // see RULE3
    (r.mode == MODE_RUN) && stop_req && !stop_enable |=> r.mode != MODE_STOP)
    else $error("stop taken while disabled");
  chk_wait_watchdog: assert property ( // see RULE1
    (r.mode == MODE_WAIT) && watchdog_enable && watchdog_expired |=>
      reset_req && vector_addr == `LPW_VEC_RESET ##1 cpu_clock_en)
    else $error("watchdog expiry in wait missed");
  chk_irq_stop_wake: assert property ( // see RULE4
    stop_mode && !stop_rst && !brk && irq_wake |=>
      r.mode == MODE_RECOVER && r.pend_vec == `LPW_VEC_EXT_INT)
    else $error("external interrupt did not wake stop");
  chk_keypad_wake: assert property ( // see RULE21
    stop_mode && !stop_rst && kp_wake |=> r.mode == MODE_RECOVER)
    else $error("keypad edge did not wake stop");
  chk_svm_stop: assert property ( // see RULE6
    stop_mode && svm_rst && svm_stop_enable |=> r.exit_by_reset && r.mode == MODE_RECOVER)
    else $error("monitor reset did not end stop");
  chk_timebase_stop: assert property ( // see RULE10
    stop_mode && !osc_in_stop_enable |=> !timebase_run && periph_halt)
    else $error("timebase ran in stop without oscillator");
  chk_wait_access: assert property ( // see RULE11
    r.mode == MODE_WAIT |=> access_block && !cpu_clock_en && bus_clock_en)
    else $error("wait access not blocked");
  chk_reset_abort: assert property ( // see RULE8
    (r.mode == MODE_RECOVER) && rec.done && r.exit_by_reset |=>
      sync_serial_abort && reset_req ##1 !sync_serial_abort)
    else $error("reset exit did not abort sync serial");
endmodule
`default_nettype wire

// >>> tb/wake_sources.sv
`timescale 1ns/10ps
`default_nettype none
// far-side stand-in: the core's peripherals and pins, one source per select code
module wake_sources (
  input  wire logic       go,
  input  wire logic [4:0] sel,
  input  wire logic       kp_pol,
  output logic            break_req,
  output logic            clkgen_irq,
  output logic [2:0]      first_timer_irq,
  output logic [6:0]      second_timer_irq,
  output logic [1:0]      sync_serial_irq,
  output logic [2:0]      async_serial_irq,
  output logic            adc_irq,
  output logic            timebase_irq,
  output logic [3:0]      can_irq,
  output logic            ext_int_n,
  output logic [7:0]      keypad_pins
);
  // request levels hold until the bench drops go, as a real peripheral flag does
  assign {break_req, clkgen_irq, first_timer_irq, second_timer_irq, sync_serial_irq,
          async_serial_irq, adc_irq, timebase_irq, can_irq}
    = (go && sel < 5'd23) ? (23'h400000 >> sel) : 23'h000000;
  // pin idles high and falls on a request
  assign ext_int_n = ~(go && sel == 5'd23);
  // idle level follows the pull chosen by polarity; only pin 0 moves on a request
  assign keypad_pins = {7'h7F ^ {7{kp_pol}}, ~kp_pol ^ (go && sel == 5'd24)};
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "lpw_regs.svh"
module tb;
  import lpw_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, go = 1'b0, kp_pol = 1'b0;
  logic [4:0] sel = 5'h00;
  logic wait_req = 1'b0, stop_req = 1'b0, stop_enable = 1'b0, short_recovery_bit = 1'b1;
  logic osc_in_stop_enable = 1'b0, watchdog_enable = 1'b0, watchdog_expired = 1'b0;
  logic reset_pin_n = 1'b1, ext_int_mask_bit = 1'b0, keypad_mask_bit = 1'b0;
  logic [7:0] keypad_enable = 8'h01, keypad_polarity_bits = 8'h00;
  logic svm_enable = 1'b1, svm_reset_enable = 1'b1, svm_stop_enable = 1'b1, svm_trip = 1'b0;
  logic emulation_mode = 1'b1, can_bus_activity = 1'b0, break_req, clkgen_irq, adc_irq;
  logic timebase_irq, ext_int_n, cpu_clock_en, bus_clock_en, in_wait, in_stop, recovering;
  logic watchdog_clock_in, sic_clear, sync_serial_freeze, sync_serial_abort, periph_halt;
  logic timebase_run, access_block, reset_req, vector_load, saw_sic, saw_abort;
  logic [2:0] first_timer_irq, async_serial_irq;
  logic [6:0] second_timer_irq;
  logic [1:0] sync_serial_irq;
  logic [3:0] can_irq;
  logic [7:0] keypad_pins;
  vec_addr_t vector_addr;
  int n_mismatch = 0, cmp_count = 0, n;
  // row i: select code i on the partner, vector that its wake must load
  vec_addr_t exp_vec [25] = '{`LPW_VEC_BREAK, `LPW_VEC_CLKGEN, `LPW_VEC_T1_CH0,
    `LPW_VEC_T1_CH1, `LPW_VEC_T1_OVF, `LPW_VEC_T2_CH5, `LPW_VEC_T2_CH4, `LPW_VEC_T2_CH3,
    `LPW_VEC_T2_CH2, `LPW_VEC_T2_CH0, `LPW_VEC_T2_CH1, `LPW_VEC_T2_OVF, `LPW_VEC_SSI_RX,
    `LPW_VEC_SSI_TX, `LPW_VEC_ASI_ERR, `LPW_VEC_ASI_RX, `LPW_VEC_ASI_TX, `LPW_VEC_ADC,
    `LPW_VEC_TIMEBASE, `LPW_VEC_CAN_WAKE, `LPW_VEC_CAN_ERR, `LPW_VEC_CAN_RX,
    `LPW_VEC_CAN_TX, `LPW_VEC_EXT_INT, `LPW_VEC_KEYPAD};

  low_power_wakeup_control DUT (.clk_sys, .resetn, .wait_req, .stop_req, .stop_enable,
    .short_recovery_bit, .osc_in_stop_enable, .watchdog_enable, .watchdog_expired,
    .reset_pin_n, .ext_int_n, .ext_int_mask_bit, .keypad_pins, .keypad_enable,
    .keypad_polarity_bits, .keypad_mask_bit, .svm_enable, .svm_reset_enable,
    .svm_stop_enable, .svm_trip, .break_req, .emulation_mode, .clkgen_irq,
    .first_timer_irq, .second_timer_irq, .sync_serial_irq, .async_serial_irq, .adc_irq,
    .timebase_irq, .can_irq, .can_bus_activity, .cpu_clock_en, .bus_clock_en, .in_wait,
    .in_stop, .recovering, .watchdog_clock_in, .sic_clear, .sync_serial_freeze,
    .sync_serial_abort, .periph_halt, .timebase_run, .access_block, .reset_req,
    .vector_load, .vector_addr);
  wake_sources partner (.go, .sel, .kp_pol, .break_req, .clkgen_irq, .first_timer_irq,
    .second_timer_irq, .sync_serial_irq, .async_serial_irq, .adc_irq, .timebase_irq,
    .can_irq, .ext_int_n, .keypad_pins);

  always #20 clk_sys = ~clk_sys;
  // pulses are caught here so their exact cycle need not be guessed
  always @(posedge clk_sys) begin
    if (sic_clear === 1'b1) saw_sic <= 1'b1;
    if (sync_serial_abort === 1'b1) saw_abort <= 1'b1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // drive point is always 2 ns after the rising edge
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #2;
  endtask
  task automatic enter(input bit stp);
    if (stp) stop_req = 1'b1;
    else wait_req = 1'b1;
    step(1);
    stop_req = 1'b0;
    wait_req = 1'b0;
    step(3);
  endtask
  // counts cycles to a vector load or a reset request; a hang ends the run
  task automatic wait_ev(input bit rst, input int lim, output int k);
    k = 0;
    while ((rst ? reset_req : vector_load) !== 1'b1) begin
      step(1);
      k++;
      if (k > lim) begin
        n_mismatch++;
        $display("ERROR %0t: no answer", $time);
        print_verdict();
      end
    end
  endtask

  initial begin
    saw_sic = 1'b0;
    saw_abort = 1'b0;
    step(3);
    resetn = 1'b1;
    check(cpu_clock_en, 1'b1);
    check(watchdog_clock_in, 1'b1);
    check(vector_addr, 16'h0000);
    // every wait-mode wake source and its vector
    for (int i = 0; i < 25; i++) begin
      sel = 5'(i);
      enter(1'b0);
      check({in_wait, cpu_clock_en, bus_clock_en}, 3'h5);
      check(access_block, 1'b1);
      check(watchdog_clock_in, 1'b1);
      go = 1'b1;
      wait_ev(1'b0, 8, n);
      check(vector_addr, exp_vec[i]);
      go = 1'b0;
      step(4);
      check(cpu_clock_en, 1'b1);
    end
    // masked pin edge must not wake, unmasked one must
    sel = 5'd23;
    ext_int_mask_bit = 1'b1;
    enter(1'b0);
    go = 1'b1;
    step(6);
    check(in_wait, 1'b1);
    go = 1'b0;
    ext_int_mask_bit = 1'b0;
    step(1);
    go = 1'b1;
    wait_ev(1'b0, 8, n);
    check(vector_addr, `LPW_VEC_EXT_INT);
    go = 1'b0;
    step(4);
    // stop instruction refused while stop is disabled
    enter(1'b1);
    check(in_stop, 1'b0);
    check(cpu_clock_en, 1'b1);
    stop_enable = 1'b1;
    enter(1'b1);
    check({in_stop, watchdog_clock_in, saw_sic}, 3'h5);
    check({periph_halt, sync_serial_freeze}, 2'h3);
    check({timebase_run, bus_clock_en}, 2'h0);
    sel = 5'd4;
    go = 1'b1;
    step(6);
    check(in_stop, 1'b1);
    go = 1'b0;
    sel = 5'd23;
    step(1);
    go = 1'b1;
    step(3);
    check({recovering, cpu_clock_en}, 2'h2);
    wait_ev(1'b0, 60, n);
    check(n >= 30 && n <= 34, 1'b1);
    check(vector_addr, `LPW_VEC_EXT_INT);
    go = 1'b0;
    step(4);
    // oscillator kept: timebase runs and its rollover wakes
    osc_in_stop_enable = 1'b1;
    sel = 5'd18;
    enter(1'b1);
    check({timebase_run, bus_clock_en}, 2'h3);
    go = 1'b1;
    wait_ev(1'b0, 60, n);
    check(vector_addr, `LPW_VEC_TIMEBASE);
    go = 1'b0;
    // keypad rising edge with polarity set
    kp_pol = 1'b1;
    keypad_polarity_bits = 8'h01;
    sel = 5'd24;
    step(4);
    enter(1'b1);
    go = 1'b1;
    wait_ev(1'b0, 60, n);
    check(vector_addr, `LPW_VEC_KEYPAD);
    go = 1'b0;
    step(4);
    enter(1'b1);
    can_bus_activity = 1'b1;
    wait_ev(1'b0, 60, n);
    check(vector_addr, `LPW_VEC_CAN_WAKE);
    can_bus_activity = 1'b0;
    step(4);
    // monitor reset ends stop after the full recovery and aborts the serial link
    short_recovery_bit = 1'b0;
    enter(1'b1);
    saw_abort = 1'b0;
    svm_trip = 1'b1;
    wait_ev(1'b1, 4200, n);
    svm_trip = 1'b0;
    check(n >= 4097 && n <= 4102, 1'b1);
    check(vector_addr, `LPW_VEC_RESET);
    step(3);
    check(saw_abort, 1'b1);
    enter(1'b0);
    watchdog_enable = 1'b1;
    watchdog_expired = 1'b1;
    wait_ev(1'b1, 8, n);
    check(reset_req, 1'b1);
    watchdog_expired = 1'b0;
    step(4);
    reset_pin_n = 1'b0;
    wait_ev(1'b1, 8, n);
    check(reset_req, 1'b1);
    reset_pin_n = 1'b1;
    step(2);
    // reset in mid-stop must return stop, access block, watchdog clock, vector and cpu clock to their idle levels
    enter(1'b1);
    resetn = 1'b0;
    step(1);
    resetn = 1'b1;
    check({in_stop, access_block, watchdog_clock_in}, 3'h1);
    check(vector_addr, 16'h0000);
    step(2);
    check({in_stop, cpu_clock_en}, 2'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
